/* File: verilog/fault_regs.svh */
`ifndef FAULT_REGS_SVH
`define FAULT_REGS_SVH

// ======================================================
// register indices (byte address = 4 * index)
`define IDX_POLICY 12'h051
`define IDX_MASKED 12'h084
`define IDX_CLEAR 12'h086
`define IDX_STATUS 12'h090
`define IDX_ENABLE 12'h091
`define IDX_CTRL 12'h092
`define IDX_STATE 12'h093
`define IDX_IRQ_STAT 12'h094
`define IDX_IRQ_MASK 12'h095

// ======================================================
// reset values and field constants
`define RST_POLICY 16'h6403
`define RST_CLEAR 16'h0000
`define RST_STATUS 16'h0000
`define RST_ENABLE 16'hffff
`define FORCED_FAULTS 16'h0003
`define BIT_GATE_KILL 0
`define CLEAR_GO 16'h0001
`define RETRY_NONE 8'h00
`define RETRY_UNLIMITED 8'hff

// ======================================================
// interrupt status bits
`define IRQ_W 4
`define IRQ_FAULT 0
`define IRQ_CLEARED 1
`define IRQ_RESTART 2
`define IRQ_EXHAUST 3

// ======================================================
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ======================================================
// timing
`define CLK_NS 10
`define TENTH_US 100000
`define TENTH_CYCLES (`TENTH_US * 1000 / `CLK_NS)
`define PWM_DIV_DEFAULT 5000

`endif

/* File: verilog/fault_pkg.sv */
package fault_pkg;

	// motor command source
	typedef enum logic [1:0] {SRC_HOST, SRC_FREQ, SRC_DUTY, SRC_VSP} cmd_src_t;

	// drive state
	typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_FAULT} drive_state_t;

	// restart policy word: delay in high byte, count in low byte
	typedef struct packed {
		logic [7:0] delay;
		logic [7:0] count;
	} policy_t;

	// control word: bits [2:1] source, bit 0 run request
	typedef struct packed {
		cmd_src_t src;
		logic run;
	} ctrl_t;

endpackage : fault_pkg

/* File: verilog/restart_timer.sv */
`timescale 1ns/1ps
`include "fault_regs.svh"

// counts a restart delay in tenth-second units
module restart_timer
	import fault_pkg::*;
#(
	parameter int unsigned TENTH_CYCLES = `TENTH_CYCLES
)
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic start, // load units and begin
	input wire logic abort, // drop a running wait
	input wire logic [7:0] units, // wait in 0.1 s steps
	output logic expired, // one-cycle pulse at the end
	output logic busy // wait in progress
);

	localparam int PW = $clog2(TENTH_CYCLES + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(TENTH_CYCLES - 1);

	logic [PW-1:0] pre_r, pre_nxt; // cycles inside one tenth
	logic [7:0] left_r, left_nxt; // tenths still to wait
	logic busy_r, busy_nxt;
	logic exp_r, exp_nxt;

	// ======================================================
	// prescaler and unit counter
	always_comb
	begin
		pre_nxt = pre_r;
		left_nxt = left_r;
		busy_nxt = busy_r;
		exp_nxt = 1'b0;
		if (abort)
		begin
			busy_nxt = 1'b0; // leaving the fault state drops the wait
		end
		else if (start)
		begin
			busy_nxt = 1'b1;
			left_nxt = units;
			pre_nxt = '0;
		end
		else if (busy_r)
		begin
			if (left_r == 8'h00)
			begin
				busy_nxt = 1'b0; // zero units expire at once
				exp_nxt = 1'b1;
			end
			else if (pre_r == PRE_LAST)
			begin
				pre_nxt = '0;
				left_nxt = left_r - 8'h01;
			end
			else
			begin
				pre_nxt = pre_r + PW'(1);
			end
		end
	end

	// registers only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pre_r <= '0;
			left_r <= 8'h00;
			busy_r <= 1'b0;
			exp_r <= 1'b0;
		end
		else
		begin
			pre_r <= pre_nxt;
			left_r <= left_nxt;
			busy_r <= busy_nxt;
			exp_r <= exp_nxt;
		end
	end

	assign expired = exp_r;
	assign busy = busy_r;

endmodule : restart_timer

/* File: verilog/drive_fault_retry_clear.sv */
`timescale 1ns/1ps
`include "fault_regs.svh"

module drive_fault_retry_clear
	import fault_pkg::*;
#(
	parameter int unsigned TENTH_CYCLES = `TENTH_CYCLES, // cycles per 0.1 s
	parameter int unsigned PWM_DIV = `PWM_DIV_DEFAULT, // cycles per PWM period
	parameter int ADDR_W = 14 // byte address width
)
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low
	input wire logic [ADDR_W-1:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write byte lanes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [ADDR_W-1:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic [15:0] fault_cond_in, // raw fault conditions, async
	output logic inverter_off, // inverter shut down
	output logic regulator_off, // regulator shut down
	output logic [1:0] drive_state, // current drive_state_t
	output logic restart_start, // pulse: automatic motor start
	output logic fault_irq // level interrupt
);

	// ======================================================
	// declarations
	logic [15:0] cond_s1_r, cond_s2_r; // input synchroniser
	logic [31:0] pwm_cnt_r, pwm_cnt_nxt; // PWM rate divider
	logic pwm_tick;
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [11:0] aw_idx_r, aw_idx_nxt; // held write index
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic do_wr; // both halves of a write present
	logic [15:0] wr16; // byte-masked write value helper
	logic [15:0] rd_word; // read mux
	logic rd_ok, wr_ok; // address decodes
	policy_t policy_r, policy_nxt;
	logic clear_r, clear_nxt; // pending clear command
	logic [15:0] flags_r, flags_nxt; // fault status word
	logic [15:0] enable_r, enable_nxt; // fault enable mask
	ctrl_t ctrl_r, ctrl_nxt;
	drive_state_t state_r, state_nxt;
	logic [7:0] retries_r, retries_nxt; // attempts left
	logic arm_r, arm_nxt; // timer already used this attempt
	logic [`IRQ_W-1:0] irq_r, irq_nxt, irq_mask_r, irq_mask_nxt;
	logic inv_r, inv_nxt, reg_r, reg_nxt, rst_r, rst_nxt;
	logic [15:0] sampled, eff_mask, masked, active;
	logic clear_now, auto_ok, auto_clear, tmr_start, tmr_exp, tmr_busy;
	logic src_ok;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// ======================================================
	// fault sampling
	// pins are asynchronous, so two flops before any use
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cond_s1_r <= 16'h0000;
			cond_s2_r <= 16'h0000;
			pwm_cnt_r <= 32'h0000_0000;
		end
		else
		begin
			cond_s1_r <= fault_cond_in;
			cond_s2_r <= cond_s1_r;
			pwm_cnt_r <= pwm_cnt_nxt;
		end
	end

	// PWM tick divider
	always_comb
	begin
		pwm_tick = (pwm_cnt_r == 32'(PWM_DIV - 1));
		pwm_cnt_nxt = pwm_tick ? 32'h0000_0000 : pwm_cnt_r + 32'h0000_0001;
	end

	// gate shutoff enters every cycle, the rest only on a PWM tick
	assign sampled = pwm_tick ? cond_s2_r : (cond_s2_r & (16'h0001 << `BIT_GATE_KILL));
	assign eff_mask = enable_r | `FORCED_FAULTS;
	assign masked = flags_r & eff_mask;
	assign active = cond_s2_r & eff_mask;

	// ======================================================
	// restart policy decisions
	assign src_ok = (ctrl_r.src == SRC_FREQ) || (ctrl_r.src == SRC_DUTY) || (ctrl_r.src == SRC_VSP);
	assign auto_ok = (state_r == ST_FAULT) && src_ok && (retries_r != `RETRY_NONE);
	assign tmr_start = auto_ok && !arm_r && !tmr_busy;
	assign auto_clear = tmr_exp && auto_ok;
	assign clear_now = clear_r || auto_clear;

	restart_timer #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(tmr_start),
		.abort(state_r != ST_FAULT),
		.units(policy_r.delay),
		.expired(tmr_exp),
		.busy(tmr_busy)
	);

	// ======================================================
	// register bus slave
	assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
	assign awready = !aw_hold_r;
	assign wready = !w_hold_r;
	assign arready = !rvalid_r;
	assign wr16 = wdata_r[15:0] & {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

	// write decode
	always_comb
	begin
		case (aw_idx_r)
			`IDX_POLICY, `IDX_MASKED, `IDX_CLEAR, `IDX_STATUS, `IDX_ENABLE,
			`IDX_CTRL, `IDX_STATE, `IDX_IRQ_STAT, `IDX_IRQ_MASK: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	// read mux, narrower registers padded with zero
	always_comb
	begin
		rd_ok = 1'b1;
		case (araddr[ADDR_W-1:2])
			`IDX_POLICY: rd_word = policy_r;
			`IDX_MASKED: rd_word = masked;
			`IDX_CLEAR: rd_word = {15'h0000, clear_r};
			`IDX_STATUS: rd_word = flags_r;
			`IDX_ENABLE: rd_word = enable_r;
			`IDX_CTRL: rd_word = {13'h0000, ctrl_r};
			`IDX_STATE: rd_word = {retries_r, 6'h00, state_r};
			`IDX_IRQ_STAT: rd_word = {12'h000, irq_r};
			`IDX_IRQ_MASK: rd_word = {12'h000, irq_mask_r};
			default:
			begin
				rd_word = 16'h0000;
				rd_ok = 1'b0; // unmapped answers slave error
			end
		endcase
	end

	// channel handshakes
	always_comb
	begin
		aw_hold_nxt = aw_hold_r;
		aw_idx_nxt = aw_idx_r;
		w_hold_nxt = w_hold_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (awvalid && !aw_hold_r)
		begin
			aw_hold_nxt = 1'b1;
			aw_idx_nxt = awaddr[ADDR_W-1:2];
		end
		if (wvalid && !w_hold_r)
		begin
			w_hold_nxt = 1'b1;
			wdata_nxt = wdata;
			wstrb_nxt = wstrb;
		end
		if (do_wr)
		begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (bvalid_r && bready)
		begin
			bvalid_nxt = 1'b0;
		end
		if (arvalid && !rvalid_r)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt = {16'h0000, rd_word};
			rresp_nxt = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		else if (rvalid_r && rready)
		begin
			rvalid_nxt = 1'b0;
		end
	end

	// ======================================================
	// fault core, drive state and interrupts
	always_comb
	begin
		policy_nxt = policy_r;
		enable_nxt = enable_r;
		ctrl_nxt = ctrl_r;
		irq_mask_nxt = irq_mask_r;
		retries_nxt = retries_r;
		state_nxt = state_r;
		rst_nxt = 1'b0;
		irq_nxt = irq_r;
		// a pending clear is carried out now, so it drops back
		clear_nxt = 1'b0;
		// software writes
		if (do_wr)
		begin
			case (aw_idx_r)
				`IDX_POLICY:
				begin
					policy_nxt = merge16(policy_r, wdata_r, wstrb_r);
					retries_nxt = policy_nxt.count;
				end
				// values other than one are out of range and ignored
				`IDX_CLEAR: clear_nxt = (wr16 == `CLEAR_GO) && (&wstrb_r[1:0]);
				`IDX_ENABLE: enable_nxt = merge16(enable_r, wdata_r, wstrb_r);
				`IDX_CTRL: if (wstrb_r[0]) ctrl_nxt = ctrl_t'(wdata_r[2:0]);
				`IDX_IRQ_STAT: irq_nxt = irq_r & ~wr16[`IRQ_W-1:0];
				`IDX_IRQ_MASK: if (wstrb_r[0]) irq_mask_nxt = wdata_r[`IRQ_W-1:0];
				default: ;
			endcase
		end
		// faults latch; a new one in the clear cycle wins
		flags_nxt = (clear_now ? 16'h0000 : flags_r) | sampled;
		// retry bookkeeping on each expiry
		if (auto_clear && retries_r != `RETRY_UNLIMITED)
		begin
			retries_nxt = retries_r - 8'h01;
			if (retries_r == 8'h01)
				irq_nxt[`IRQ_EXHAUST] = 1'b1;
		end
		case (state_r)
			ST_STOP:
			begin
				if (masked != 16'h0000)
					state_nxt = ST_FAULT;
				else if (ctrl_r.run)
					state_nxt = ST_RUN;
			end
			ST_RUN:
			begin
				if (masked != 16'h0000)
					state_nxt = ST_FAULT;
				else if (!ctrl_r.run)
					state_nxt = ST_STOP;
			end
			ST_FAULT:
			begin
				// a fault still present keeps the drive faulted
				if (clear_now && active == 16'h0000)
				begin
					if (auto_clear)
					begin
						state_nxt = ST_RUN;
						ctrl_nxt.run = 1'b1;
						rst_nxt = 1'b1;
						irq_nxt[`IRQ_RESTART] = 1'b1;
					end
					else
					begin
						state_nxt = ST_STOP;
						retries_nxt = policy_r.count;
					end
				end
			end
			default: state_nxt = ST_STOP;
		endcase
		// entering fault drops the run request; only a software write or an automatic restart sets it again
		if (state_r != ST_FAULT && state_nxt == ST_FAULT)
		begin
			ctrl_nxt.run = 1'b0;
			irq_nxt[`IRQ_FAULT] = 1'b1;
		end
		if (clear_now)
			irq_nxt[`IRQ_CLEARED] = 1'b1;
		// timer is armed once per attempt
		if (state_r != ST_FAULT || tmr_exp)
			arm_nxt = 1'b0;
		else
			arm_nxt = arm_r | tmr_start;
		// gate shutoff stops both stages without waiting for a tick
		inv_nxt = (state_nxt == ST_FAULT) || cond_s2_r[`BIT_GATE_KILL];
		reg_nxt = cond_s2_r[`BIT_GATE_KILL] || (reg_r && state_nxt == ST_FAULT);
	end

	// registers only
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			aw_idx_r <= 12'h000;
			w_hold_r <= 1'b0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `RESP_OKAY;
			policy_r <= `RST_POLICY;
			clear_r <= 1'b0;
			flags_r <= `RST_STATUS;
			enable_r <= `RST_ENABLE;
			ctrl_r <= ctrl_t'(3'h0);
			irq_mask_r <= 4'h0;
			irq_r <= 4'h0;
			retries_r <= 8'h03;
			state_r <= ST_STOP;
			arm_r <= 1'b0;
			inv_r <= 1'b0;
			reg_r <= 1'b0;
			rst_r <= 1'b0;
		end
		else
		begin
			aw_hold_r <= aw_hold_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_hold_r <= w_hold_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			policy_r <= policy_nxt;
			clear_r <= clear_nxt;
			flags_r <= flags_nxt;
			enable_r <= enable_nxt;
			ctrl_r <= ctrl_nxt;
			irq_mask_r <= irq_mask_nxt;
			irq_r <= irq_nxt;
			retries_r <= retries_nxt;
			state_r <= state_nxt;
			arm_r <= arm_nxt;
			inv_r <= inv_nxt;
			reg_r <= reg_nxt;
			rst_r <= rst_nxt;
		end
	end

	// ======================================================
	// outputs
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign inverter_off = inv_r;
	assign regulator_off = reg_r;
	assign drive_state = state_r;
	assign restart_start = rst_r;
	assign fault_irq = |(irq_r & irq_mask_r);

endmodule : drive_fault_retry_clear

/* File: testbench/drive_fault_asserts.sv */
`timescale 1ns/1ps

// ==========================================
// checker on the top-level ports
module drive_fault_asserts
	import fault_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic aresetn, // sync reset, low
	input wire logic awvalid, // write address valid
	input wire logic awready, // write address ready
	input wire logic wvalid, // write data valid
	input wire logic wready, // write data ready
	input wire logic [1:0] bresp, // write response
	input wire logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic arvalid, // read address valid
	input wire logic arready, // read address ready
	input wire logic [31:0] rdata, // read data
	input wire logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic [15:0] fault_cond_in, // raw fault levels
	input wire logic inverter_off, // inverter shut down
	input wire logic regulator_off, // regulator shut down
	input wire logic [1:0] drive_state, // drive state
	input wire logic restart_start, // restart pulse
	input wire logic fault_irq // level interrupt
);
	// one clock domain, so one default clocking and reset
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================
	// fault path
	a_gate_shutdown: assert property (fault_cond_in[0] [*3] |=> inverter_off && regulator_off)
		else $error("gate shutoff did not stop inverter and regulator");
	a_fault_inverter: assert property (drive_state == ST_FAULT [*2] |-> inverter_off)
		else $error("inverter running in fault state");
	a_restart_pulse: assert property (restart_start |=> !restart_start)
		else $error("restart pulse longer than one cycle");
	a_restart_run: assert property (restart_start |-> ##[0:2] drive_state == ST_RUN)
		else $error("restart pulse without run state");
	a_state_legal: assert property (drive_state != 2'h3)
		else $error("drive state encoding out of range");

	// ==========================================
	// register bus
	// both halves sit one cycle in holding flops, then the response flop loads
	a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read response late");
	a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before accept");
	a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before accept");
	a_read_block: assert property (rvalid |-> !arready)
		else $error("read address accepted while data pending");
	a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");

	// main scenarios reached
	c_restart: cover property (restart_start);
	c_clear_stop: cover property (drive_state == ST_FAULT ##1 drive_state == ST_STOP);
	c_gate: cover property (inverter_off && regulator_off);
	c_irq: cover property (fault_irq);
endmodule : drive_fault_asserts

bind drive_fault_retry_clear drive_fault_asserts i_drive_fault_asserts (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.fault_cond_in(fault_cond_in), .inverter_off(inverter_off), .regulator_off(regulator_off),
	.drive_state(drive_state), .restart_start(restart_start), .fault_irq(fault_irq));

/* File: testbench/drive_fault_retry_clear_tb.sv */
`timescale 1ns/1ps
`include "fault_regs.svh"

// ==========================================
// self-checking bench over the register bus
module drive_fault_retry_clear_tb
	import fault_pkg::*;
;
	localparam int TC = 8; // short tenth-second count
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid, awready, wready, arready;
	logic [13:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rd_resp, wr_resp, drive_state;
	logic [15:0] fault_cond_in;
	logic inverter_off, regulator_off, restart_start, fault_irq, seen;
	int mismatches, checks, cycles, cyc;

	drive_fault_retry_clear #(.TENTH_CYCLES(TC), .PWM_DIV(4)) i_drive_fault_retry_clear (.aclk(aclk),
		.aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.fault_cond_in(fault_cond_in), .inverter_off(inverter_off), .regulator_off(regulator_off),
		.drive_state(drive_state), .restart_start(restart_start), .fault_irq(fault_irq));

	// clock, 10 ns period
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// hang guard: well above the expected run length
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			give_verdict();
		end
	end

	// ==========================================
	// helpers
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// write: both channels offered together, bready raised once bvalid is seen
	task wr(input logic [11:0] idx, input logic [15:0] d);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {16'h0000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				done = 1'b1;
				wr_resp = bresp;
				bready <= 1'b0;
			end
			else if (bvalid) bready <= 1'b1;
		end
	endtask : wr

	// read: rready raised late so the hold of rdata is exercised
	task rd(input logic [11:0] idx);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		while (!done)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				done = 1'b1;
				rd_data = rdata;
				rd_resp = rresp;
				rready <= 1'b0;
			end
			else if (rvalid) rready <= 1'b1;
		end
	endtask : rd

	// hold one fault line long enough to span a pwm tick
	task pulse_fault(input int b);
		fault_cond_in[b] <= 1'b1;
		repeat (6) @(posedge aclk);
		fault_cond_in[b] <= 1'b0;
	endtask : pulse_fault

	task wait_restart(input int n);
		seen = 1'b0;
		repeat (n)
		begin
			@(posedge aclk);
			if (restart_start) seen = 1'b1;
		end
	endtask : wait_restart

	task give_verdict();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	// ==========================================
	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb, fault_cond_in} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`IDX_POLICY); chk(rd_data, 32'h00006403);
		rd(`IDX_CLEAR); chk(rd_data, 32'h0);
		rd(`IDX_STATUS); chk(rd_data, 32'h0);
		rd(12'h0ff); chk(32'(rd_resp), 32'(`RESP_SLVERR));
		wr(12'h0ff, 16'h0001); chk(32'(wr_resp), 32'(`RESP_SLVERR));
		wr(`IDX_STATUS, 16'hffff); chk(32'(wr_resp), 32'(`RESP_OKAY));
		rd(`IDX_STATUS); chk(rd_data, 32'h0);
		$display("test reset values done");
		// a persisting fault survives a clear; host source never restarts
		fault_cond_in[2] <= 1'b1;
		repeat (12) @(posedge aclk);
		chk(32'(drive_state), 32'(ST_FAULT));
		rd(`IDX_STATUS); chk(rd_data, 32'h4);
		rd(`IDX_MASKED); chk(rd_data, 32'h4);
		chk(32'(fault_irq), 32'h0);
		wr(`IDX_CLEAR, 16'h0001); rd(`IDX_CLEAR); chk(rd_data, 32'h0);
		chk(32'(drive_state), 32'(ST_FAULT));
		wait_restart(30); chk(32'(seen), 32'h0);
		fault_cond_in[2] <= 1'b0;
		repeat (8) @(posedge aclk);
		// a zero is outside the allowed range and must not clear anything
		wr(`IDX_CLEAR, 16'h0000); rd(`IDX_STATUS); chk(32'(drive_state), 32'(ST_FAULT));
		wr(`IDX_CLEAR, 16'h0001); rd(`IDX_STATUS); chk(rd_data, 32'h0);
		chk(32'(drive_state), 32'(ST_STOP));
		rd(`IDX_MASKED); chk(rd_data, 32'h0);
		$display("test clear done");
		// enable mask off: ordinary fault ignored, critical one not; interrupt path
		// old events acknowledged first, so the interrupt level below means something
		wr(`IDX_ENABLE, 16'h0000); wr(`IDX_IRQ_STAT, 16'h000f); wr(`IDX_IRQ_MASK, 16'h0001);
		pulse_fault(2); repeat (6) @(posedge aclk);
		chk(32'(drive_state), 32'(ST_STOP));
		chk(32'(fault_irq), 32'h0);
		rd(`IDX_MASKED); chk(rd_data, 32'h0);
		pulse_fault(1); repeat (6) @(posedge aclk);
		chk(32'(drive_state), 32'(ST_FAULT));
		chk(32'(fault_irq), 32'h1);
		wr(`IDX_IRQ_STAT, 16'h000f); chk(32'(fault_irq), 32'h0);
		wr(`IDX_CLEAR, 16'h0001);
		// gate shutoff acts at once, even with the mask off
		fault_cond_in[0] <= 1'b1;
		repeat (4) @(posedge aclk);
		chk(32'({inverter_off, regulator_off}), 32'h3);
		fault_cond_in[0] <= 1'b0;
		repeat (4) @(posedge aclk);
		wr(`IDX_CLEAR, 16'h0001); rd(`IDX_STATUS); chk(32'(drive_state), 32'(ST_STOP));
		wr(`IDX_ENABLE, 16'hffff);
		$display("test mask and gate done");
		// every command source, zero delay
		for (int s = 0; s < 4; s++)
		begin
			wr(`IDX_POLICY, 16'h0005); wr(`IDX_CTRL, {13'h0, 2'(s), 1'b0});
			pulse_fault(2); wait_restart(40); chk(32'(seen), 32'(s != 0));
			if (!seen) wr(`IDX_CLEAR, 16'h0001);
		end
		wr(`IDX_POLICY, 16'h0000); pulse_fault(2); wait_restart(60);
		chk(32'(seen), 32'h0);
		// delay byte 2 gives two tenth-second units
		wr(`IDX_CLEAR, 16'h0001); wr(`IDX_POLICY, 16'h0203);
		fault_cond_in[2] <= 1'b1;
		cyc = 0;
		while (drive_state !== ST_FAULT && cyc < 100)
		begin
			@(posedge aclk);
			cyc++;
		end
		fault_cond_in[2] <= 1'b0;
		cyc = 0;
		while (cyc < 200)
		begin
			@(posedge aclk);
			if (restart_start) break;
			cyc++;
		end
		chk(32'(cyc >= 2 * TC && cyc <= 2 * TC + 6), 32'h1);
		rd(`IDX_STATE); chk(rd_data, 32'h0201);
		rd(`IDX_STATUS); chk(rd_data, 32'h0);
		// count 255 keeps restarting without spending attempts
		wr(`IDX_POLICY, 16'h00ff); pulse_fault(2); wait_restart(60);
		chk(32'(seen), 32'h1);
		rd(`IDX_STATE); chk(32'(rd_data[15:8]), 32'hff);
		$display("test restart done");
		give_verdict();
	end
endmodule : drive_fault_retry_clear_tb
